// ==== hdl/asp_port.sv ====
// serial port mode and status control with apb registers
// How it works
// - enable off releases pins, stops baud clock, transmit and receive
// - pin usage code picks driven pins
// - wake enable: irq on fall, clear on rise
// - echo bit selects loopback or normal
// - infrared codec only in 16x mode
// - 9-bit address mode keeps bit8 words
// - quiet flag reads one when receiver idle
// - parity flag of head word
// - framing flag of head word
// - overflow sets sticky flag until cleared
// - clearing overflow empties buffer and shifter
// - available flag shows buffer not empty
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ns
module asp_port
  import asp_pkg::*;
#(
  parameter int unsigned DEPTH = 4
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sleep_req,
  input  wire logic        rx_pin,
  output logic             tx_pin,
  output logic             tx_pin_oe,
  input  wire logic        clear_to_send_pin_n,
  output logic             request_to_send_pin_n,
  output logic             request_to_send_pin_oe,
  output logic             baud_clock_out,
  output logic             baud_clock_out_oe,
  output logic             wake_irq
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("DEPTH must be a power of two and at least 2");
  end

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [15:0]            mode;
    logic                   address_match_mode;
    logic                   rx_overflow_flag;
    logic [15:0]            brg;
    logic [15:0]            div;
    logic [DEPTH-1:0][10:0] mem;
    logic [AW-1:0]          wp;
    logic [AW-1:0]          rp;
    logic [AW:0]            cnt;
    logic                   pready;
    logic                   pslverr;
    logic [31:0]            prdata;
    logic                   tx_pin;
    logic                   tx_oe;
    logic                   rts_n;
    logic                   rts_oe;
    logic                   bclk;
    logic                   bclk_oe;
    logic                   pin_q;
    logic                   lin_q;
    logic                   wk_seen;
    logic                   wake_irq;
    logic                   ab_on;
    logic [2:0]             ab_edges;
    logic [23:0]            ab_cnt;
    logic                   flush;
  } asp_state_s;
  asp_state_s s;
  asp_state_s n;

  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
    is_reg = a == off;
  endfunction

  function automatic logic [15:0] rate(input logic [23:0] c, input logic hi);
    logic [23:0] q;
    q = hi ? (c >> AB_SH_HI) : (c >> AB_SH_LO);
    rate = (q == 24'h000000) ? 16'h0000 : q[15:0] - 16'h0001;
  endfunction

  // ****************************************************************
  // datapath
  // ****************************************************************
  logic       port_en;
  logic [1:0] pin_usage_select;
  logic [1:0] pdsel;
  logic       ir_on;
  logic       tick;
  logic [4:0] tpb;
  logic       pin_in;
  logic       rx_line;
  logic       tx_line;
  logic       tx_busy;
  logic       tx_ir;
  logic       tx_load;
  logic       rx_valid;
  logic [8:0] rx_word;
  logic       rx_pe;
  logic       rx_fe;
  logic       rx_busy;
  logic       rd_acc;
  logic       wr_acc;
  logic       mapped;
  logic       addr_on;
  logic       accept;
  logic       full;
  logic       ovf;
  logic       rx_overflow_flag_clr;
  logic       push;
  logic       pop;
  logic       fall;
  logic       nonempty;
  logic [10:0] head;
  logic [31:0] rd_val;

  assign port_en  = s.mode[EN_B];
  assign pin_usage_select      = s.mode[UEN_B+:2];
  assign pdsel    = s.mode[PDSEL_B+:2];
  assign ir_on    = s.mode[INFRARED_CODEC_ENABLE_B] && !s.mode[RATE_GEN_SPEED_B];
  assign tick     = port_en && (s.div == s.brg);
  assign tpb      = s.mode[RATE_GEN_SPEED_B] ? TPB_HI : TPB_LO;
  // the decoder is a plain inversion: pulses shorter than a sample may be missed
  assign pin_in   = rx_pin ^ s.mode[RXINV_B] ^ ir_on;
  assign rx_line  = s.mode[LPBK_B] ? tx_line : pin_in;
  assign rd_acc   = psel && penable && s.pready && !s.pslverr && !pwrite;
  assign wr_acc   = psel && penable && s.pready && !s.pslverr && pwrite;
  assign mapped   = is_reg(paddr, A_MODE) || is_reg(paddr, A_STA) || is_reg(paddr, A_TXD)
                    || is_reg(paddr, A_RXD) || is_reg(paddr, A_BRG);
  // no transmit buffer: a word written while busy, or while cts is high in flow mode, is dropped
  assign tx_load  = wr_acc && is_reg(paddr, A_TXD) && !tx_busy && port_en
                    && (pin_usage_select != UEN_FLOW || !clear_to_send_pin_n);
  assign addr_on  = s.address_match_mode && pdsel == PD_9N;
  assign accept   = rx_valid && !(addr_on && !rx_word[8]);
  assign full     = s.cnt == (AW+1)'(DEPTH);
  assign ovf      = accept && full;
  assign rx_overflow_flag_clr = wr_acc && is_reg(paddr, A_STA) && !pwdata[RX_OVERFLOW_FLAG_B] && s.rx_overflow_flag && !ovf;
  assign push     = accept && !full && !rx_overflow_flag_clr;
  assign nonempty = s.cnt != '0;
  assign pop      = rd_acc && is_reg(paddr, A_RXD) && nonempty;
  assign fall     = s.lin_q && !rx_line;
  assign head     = s.mem[s.rp];

  always_comb begin
    rd_val = 32'h00000000;
    if (is_reg(paddr, A_MODE)) begin
      rd_val[15:0] = s.mode;
    end else if (is_reg(paddr, A_STA)) begin
      rd_val[TRMT_B]  = !tx_busy;
      rd_val[ADDRESS_MATCH_MODE_B] = s.address_match_mode;
      rd_val[RX_QUIET_FLAG_B] = !rx_busy;
      rd_val[PARITY_FAULT_FLAG_B]  = nonempty && head[10];
      rd_val[STOP_BIT_FAULT_FLAG_B]  = nonempty && head[9];
      rd_val[RX_OVERFLOW_FLAG_B]  = s.rx_overflow_flag;
      rd_val[RX_WORD_AVAILABLE_B] = nonempty;
    end else if (is_reg(paddr, A_RXD)) begin
      rd_val[8:0] = head[8:0];
    end else if (is_reg(paddr, A_BRG)) begin
      rd_val[15:0] = s.brg;
    end
  end

  asp_tx u_tx (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick),
    .tpb     (tpb),
    .load    (tx_load),
    .word    (pwdata[8:0]),
    .nine    (pdsel == PD_9N),
    .par_en  (pdsel == PD_8E || pdsel == PD_8O),
    .par_odd (pdsel == PD_8O),
    .stop2   (s.mode[STSEL_B]),
    .line    (tx_line),
    .busy    (tx_busy),
    .ir      (tx_ir)
  );

  asp_rx u_rx (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick),
    .tpb     (tpb),
    .line    (rx_line),
    .en      (port_en && !s.ab_on && !sleep_req),
    .flush   (s.flush),
    .nine    (pdsel == PD_9N),
    .par_en  (pdsel == PD_8E || pdsel == PD_8O),
    .par_odd (pdsel == PD_8O),
    .valid   (rx_valid),
    .word    (rx_word),
    .pe      (rx_pe),
    .fe      (rx_fe),
    .busy    (rx_busy)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    n          = s;
    n.pready   = psel && !penable;
    n.pslverr  = psel && !penable && !mapped;
    if (psel && !penable) n.prdata = rd_val;
    n.div      = (tick || !port_en) ? 16'h0000 : s.div + 16'h0001;
    if (tick) n.bclk = !s.bclk;
    if (wr_acc && is_reg(paddr, A_MODE)) n.mode = pwdata[15:0] & MODE_WMASK;
    if (wr_acc && is_reg(paddr, A_BRG)) n.brg = pwdata[15:0];
    if (wr_acc && is_reg(paddr, A_STA)) n.address_match_mode = pwdata[ADDRESS_MATCH_MODE_B];
    // an overflow in the clearing cycle keeps the flag set
    if (ovf) n.rx_overflow_flag = 1'b1;
    else if (rx_overflow_flag_clr) n.rx_overflow_flag = 1'b0;
    n.flush = rx_overflow_flag_clr;
    if (rx_overflow_flag_clr) begin
      n.wp  = '0;
      n.rp  = '0;
      n.cnt = '0;
    end else begin
      if (push) begin
        n.mem[s.wp] = {rx_pe, rx_fe, rx_word};
        n.wp        = s.wp + 1'b1;
      end
      if (pop) n.rp = s.rp + 1'b1;
      if (push && !pop) n.cnt = s.cnt + 1'b1;
      else if (pop && !push) n.cnt = s.cnt - 1'b1;
    end
    // wake on start bit
    n.pin_q    = pin_in;
    n.wake_irq = 1'b0;
    if (s.mode[WAKE_B]) begin
      if (s.pin_q && !pin_in) begin
        n.wk_seen  = 1'b1;
        n.wake_irq = 1'b1;
      end else if (s.wk_seen && !s.pin_q && pin_in) begin
        n.wk_seen      = 1'b0;
        n.mode[WAKE_B] = 1'b0;
      end
    end else begin
      n.wk_seen = 1'b0;
    end
    // auto-rate: start edge to fifth falling edge spans eight bits
    n.lin_q = rx_line;
    if (!s.mode[AUTO_RATE_MEASURE_B]) begin
      n.ab_on = 1'b0;
    end else if (!s.ab_on) begin
      if (fall) begin
        n.ab_on    = 1'b1;
        n.ab_cnt   = 24'h000001; // the fall cycle counts too
        n.ab_edges = 3'h0;
      end
    end else begin
      n.ab_cnt = s.ab_cnt + 24'h000001;
      if (fall) begin
        n.ab_edges = s.ab_edges + 3'h1;
        if (s.ab_edges == AB_LAST) begin
          n.ab_on         = 1'b0;
          n.mode[AUTO_RATE_MEASURE_B] = 1'b0;
          n.brg           = rate(s.ab_cnt, s.mode[RATE_GEN_SPEED_B]);
        end
      end
    end
    // pins: released to the port latches while disabled
    n.tx_oe   = port_en;
    n.tx_pin  = s.mode[LPBK_B] ? !ir_on : (ir_on ? tx_ir : tx_line);
    n.rts_oe  = port_en && (pin_usage_select == UEN_RTS || pin_usage_select == UEN_FLOW);
    n.rts_n   = s.mode[RTSMD_B] ? !tx_busy : full;
    n.bclk_oe = port_en && pin_usage_select == UEN_BCLK;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{mode: MODE_RST, brg: BRG_RST, tx_pin: 1'b1, rts_n: 1'b1, pin_q: 1'b1, lin_q: 1'b1, default: '0};
    end else begin
      s <= n;
    end
  end

  assign prdata                 = s.prdata;
  assign pready                 = s.pready;
  assign pslverr                = s.pslverr;
  assign tx_pin                 = s.tx_pin;
  assign tx_pin_oe              = s.tx_oe;
  assign request_to_send_pin_n  = s.rts_n;
  assign request_to_send_pin_oe = s.rts_oe;
  assign baud_clock_out         = s.bclk;
  assign baud_clock_out_oe      = s.bclk_oe;
  assign wake_irq               = s.wake_irq;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_OFF_RELEASE: assert property ((tx_pin_oe || request_to_send_pin_oe || baud_clock_out_oe)
    |-> $past(s.mode[EN_B])) else $error("pin driven while port disabled");
  AST_BCLK_CODE: assert property (baud_clock_out_oe |-> $past(pin_usage_select) == UEN_BCLK)
    else $error("baud clock driven outside its code");
  AST_WAKE_CLR: assert property ((s.mode[WAKE_B] && s.wk_seen && !s.pin_q && pin_in)
    |=> !s.mode[WAKE_B] ##1 !wake_irq) else $error("wake bit not cleared on rise");
  AST_LOOP: assert property (s.mode[LPBK_B] |-> rx_line == tx_line)
    else $error("loopback not routed");
  AST_AUTO_RATE_MEASURE_DONE: assert property ((s.ab_on && fall && s.ab_edges == AB_LAST && !wr_acc)
    |=> !s.mode[AUTO_RATE_MEASURE_B] && !s.ab_on) else $error("auto rate not cleared");
  AST_IR_16X: assert property (tx_pin_oe && $past(s.mode[RATE_GEN_SPEED_B]) && !$past(s.mode[LPBK_B])
    |-> tx_pin == $past(tx_line)) else $error("infrared active in 4x mode");
  AST_ADDR_SKIP: assert property ((rx_valid && addr_on && !rx_word[8] && !pop && !rx_overflow_flag_clr)
    |=> s.cnt == $past(s.cnt)) else $error("data word kept in address mode");
  AST_QUIET: assert property ((psel && !penable && is_reg(paddr, A_STA))
    |=> prdata[RX_QUIET_FLAG_B] == !$past(rx_busy)) else $error("quiet flag wrong");
  AST_OVF_STICK: assert property ((ovf || (s.rx_overflow_flag && !rx_overflow_flag_clr)) |=> s.rx_overflow_flag)
    else $error("overflow flag not set");
  AST_FLUSH: assert property (rx_overflow_flag_clr |=> s.cnt == '0 && !s.rx_overflow_flag ##1 !rx_busy)
    else $error("flush incomplete");
  AST_AVAIL: assert property ((psel && !penable && is_reg(paddr, A_STA))
    |=> prdata[RX_WORD_AVAILABLE_B] == ($past(s.cnt) != '0)) else $error("available flag wrong");

  COV_AUTO_RATE_MEASURE: cover property (s.ab_on ##1 !s.ab_on && !s.mode[AUTO_RATE_MEASURE_B]);
  COV_OVF: cover property (ovf ##[1:50] rx_overflow_flag_clr);
  COV_WAKE: cover property (wake_irq);
  COV_ADDR: cover property (rx_valid && addr_on && !rx_word[8]);
endmodule // asp_port

// ==== hdl/asp_pkg.sv ====
// shared constants and types for the serial port mode and status block
package asp_pkg;
  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0]  A_MODE     = 8'h00;
  localparam logic [7:0]  A_STA      = 8'h04;
  localparam logic [7:0]  A_TXD      = 8'h08;
  localparam logic [7:0]  A_RXD      = 8'h0c;
  localparam logic [7:0]  A_BRG      = 8'h10;
  localparam logic [15:0] MODE_RST   = 16'h0000;
  localparam logic [15:0] MODE_WMASK = 16'hbbff;
  localparam logic [15:0] BRG_RST    = 16'h001a;
  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int EN_B    = 15;
  localparam int INFRARED_CODEC_ENABLE_B  = 12;
  localparam int RTSMD_B = 11;
  localparam int UEN_B   = 8;
  localparam int WAKE_B  = 7;
  localparam int LPBK_B  = 6;
  localparam int AUTO_RATE_MEASURE_B = 5;
  localparam int RXINV_B = 4;
  localparam int RATE_GEN_SPEED_B  = 3;
  localparam int PDSEL_B = 1;
  localparam int STSEL_B = 0;
  localparam int TRMT_B  = 8;
  localparam int ADDRESS_MATCH_MODE_B = 5;
  localparam int RX_QUIET_FLAG_B = 4;
  localparam int PARITY_FAULT_FLAG_B  = 3;
  localparam int STOP_BIT_FAULT_FLAG_B  = 2;
  localparam int RX_OVERFLOW_FLAG_B  = 1;
  localparam int RX_WORD_AVAILABLE_B = 0;
  // ****************************************************************
  // codes and counts
  // ****************************************************************
  localparam logic [1:0] UEN_TXRX = 2'h0;
  localparam logic [1:0] UEN_RTS  = 2'h1;
  localparam logic [1:0] UEN_FLOW = 2'h2;
  localparam logic [1:0] UEN_BCLK = 2'h3;
  localparam logic [1:0] PD_8E    = 2'h1;
  localparam logic [1:0] PD_8O    = 2'h2;
  localparam logic [1:0] PD_9N    = 2'h3;
  localparam logic [4:0] TPB_LO   = 5'h10;
  localparam logic [4:0] TPB_HI   = 5'h04;
  localparam logic [4:0] IR_PULSE = 5'h03;
  localparam logic [2:0] AB_LAST  = 3'h3;
  localparam int AB_SH_LO = 7;
  localparam int AB_SH_HI = 5;
  typedef enum logic [2:0] {SER_IDLE, SER_START, SER_DATA, SER_PAR, SER_STOP} asp_ser_e;
endpackage

// ==== hdl/asp_tx.sv ====
// transmit serializer with infrared pulse output
`timescale 1ns/1ns
module asp_tx
  import asp_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       tick,
  input  wire logic [4:0] tpb,
  input  wire logic       load,
  input  wire logic [8:0] word,
  input  wire logic       nine,
  input  wire logic       par_en,
  input  wire logic       par_odd,
  input  wire logic       stop2,
  output logic            line,
  output logic            busy,
  output logic            ir
);
  typedef struct packed {
    asp_ser_e   st;
    logic [4:0] tc;
    logic [3:0] bc;
    logic [8:0] sh;
    logic       par;
    logic       line;
    logic       stop_n;
  } asp_tx_s;
  asp_tx_s s;
  asp_tx_s n;
  logic    last;

  assign last = tick && (s.tc == tpb - 5'h01);
  assign line = s.line;
  assign busy = s.st != SER_IDLE;
  // the pulse rides the first ticks of every low bit
  assign ir   = busy && !s.line && (s.tc < IR_PULSE);

  always_comb begin
    n = s;
    if (tick) begin
      n.tc = last ? 5'h00 : s.tc + 5'h01;
    end
    case (s.st)
      SER_IDLE: begin
        n.line = 1'b1;
        if (load) begin
          n.st   = SER_START;
          n.sh   = word;
          n.par  = par_odd ^ (^word[7:0]);
          n.tc   = 5'h00;
          n.bc   = 4'h0;
          n.line = 1'b0;
        end
      end
      SER_START: begin
        if (last) begin
          n.st   = SER_DATA;
          n.line = s.sh[0];
          n.sh   = s.sh >> 1;
        end
      end
      SER_DATA: begin
        if (last) begin
          n.bc = s.bc + 4'h1;
          if (s.bc == (nine ? 4'h8 : 4'h7)) begin
            n.st     = par_en ? SER_PAR : SER_STOP;
            n.line   = par_en ? s.par : 1'b1;
            n.stop_n = stop2;
          end else begin
            n.line = s.sh[0];
            n.sh   = s.sh >> 1;
          end
        end
      end
      SER_PAR: begin
        if (last) begin
          n.st   = SER_STOP;
          n.line = 1'b1;
        end
      end
      default: begin
        if (last) begin
          if (s.stop_n) n.stop_n = 1'b0;
          else n.st = SER_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{st: SER_IDLE, line: 1'b1, default: '0};
    end else begin
      s <= n;
    end
  end
endmodule // asp_tx

// ==== hdl/asp_rx.sv ====
// receive deserializer with parity and framing checks
`timescale 1ns/1ns
module asp_rx
  import asp_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       tick,
  input  wire logic [4:0] tpb,
  input  wire logic       line,
  input  wire logic       en,
  input  wire logic       flush,
  input  wire logic       nine,
  input  wire logic       par_en,
  input  wire logic       par_odd,
  output logic            valid,
  output logic [8:0]      word,
  output logic            pe,
  output logic            fe,
  output logic            busy
);
  typedef struct packed {
    asp_ser_e   st;
    logic [4:0] tc;
    logic [3:0] bc;
    logic [8:0] sh;
    logic       pe;
    logic       fe;
    logic       valid;
    logic [8:0] word;
    logic       ln_q;
  } asp_rx_s;
  asp_rx_s s;
  asp_rx_s n;
  logic    last;

  assign last  = tick && (s.tc == tpb - 5'h01);
  assign valid = s.valid;
  assign word  = s.word;
  assign pe    = s.pe;
  assign fe    = s.fe;
  assign busy  = s.st != SER_IDLE;

  always_comb begin
    n = s;
    n.valid = 1'b0;
    n.ln_q  = line;
    if (tick && !last) n.tc = s.tc + 5'h01;
    case (s.st)
      SER_IDLE: begin
        // edge, not level: a low tail after auto-rate is no start
        if (s.ln_q && !line) begin
          n.st = SER_START;
          n.tc = 5'h00;
          n.pe = 1'b0;
        end
      end
      SER_START: begin
        // recheck at mid bit so a glitch is not taken for a start
        if (tick && s.tc == (tpb >> 1)) begin
          n.st = line ? SER_IDLE : SER_DATA;
          n.tc = 5'h00;
          n.bc = 4'h0;
        end
      end
      SER_DATA: begin
        if (last) begin
          n.tc        = 5'h00;
          n.sh[s.bc]  = line;
          n.bc        = s.bc + 4'h1;
          if (s.bc == (nine ? 4'h8 : 4'h7)) n.st = par_en ? SER_PAR : SER_STOP;
        end
      end
      SER_PAR: begin
        if (last) begin
          n.tc = 5'h00;
          n.pe = ((^s.sh[7:0]) ^ line) != par_odd;
          n.st = SER_STOP;
        end
      end
      default: begin
        if (last) begin
          n.fe    = !line;
          n.valid = 1'b1;
          n.word  = nine ? s.sh : {1'b0, s.sh[7:0]};
          n.st    = SER_IDLE;
        end
      end
    endcase
    if (!en || flush) begin
      n.st    = SER_IDLE;
      n.valid = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{st: SER_IDLE, ln_q: 1'b1, default: '0};
    end else begin
      s <= n;
    end
  end
endmodule // asp_rx

// ==== dv/asp_remote.sv ====
// remote serial device model facing the port's tx and rx lines
`timescale 1ns/1ns
module asp_remote (
  input  wire logic pclk,
  input  wire logic line_in,
  output logic      line_out
);
  int bt;
  initial begin
    bt = 16;
    line_out = 1'b1;
  end
  // bad parity or a low stop only when a test asks for them
  task automatic send(input logic [8:0] w, input int nb, input int par, input logic stp);
    @(posedge pclk) line_out <= 1'b0;
    repeat (bt) @(posedge pclk);
    for (int i = 0; i < nb; i++) begin
      line_out <= w[i];
      repeat (bt) @(posedge pclk);
    end
    if (par >= 0) begin
      line_out <= par[0];
      repeat (bt) @(posedge pclk);
    end
    line_out <= stp;
    repeat (bt) @(posedge pclk);
    line_out <= 1'b1;
    repeat (bt) @(posedge pclk);
  endtask
  // samples mid-bit, so a short start bit is tolerated
  task automatic recv(output logic [7:0] w);
    while (line_in !== 1'b0) @(posedge pclk);
    repeat (bt / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (bt) @(posedge pclk);
      w[i] = line_in;
    end
  endtask
endmodule // asp_remote

// ==== dv/async_serial_port_mode_status_tb.sv ====
// self-checking bench for the serial port mode and status block
`timescale 1ns/1ns
module async_serial_port_mode_status_tb;
  import asp_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, sleep_req, rx_pin, tx_pin, tx_oe, e;
  logic        pready, pslverr, rts_n, rts_oe, bclk, bclk_oe, wake_irq;
  logic [7:0]  paddr, w;
  logic [31:0] pwdata, prdata, q;
  logic [2:0]  pins [5] = '{3'h4, 3'h0, 3'h6, 3'h5, 3'h6};
  int          mismatches, n_checks, n;
  asp_port #(.DEPTH(4)) asp_port_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_req(sleep_req), .rx_pin(rx_pin), .tx_pin(tx_pin), .tx_pin_oe(tx_oe), .clear_to_send_pin_n(1'b0),
    .request_to_send_pin_n(rts_n), .request_to_send_pin_oe(rts_oe), .baud_clock_out(bclk),
    .baud_clock_out_oe(bclk_oe), .wake_irq(wake_irq));
  asp_remote asp_remote_i (.pclk(pclk), .line_in(tx_pin), .line_out(rx_pin));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait
    do @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q & m, x);
  endtask
  task automatic endt(input string s);
    $display("test %s done", s);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // generous: the whole run needs about 4000 cycles
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    print_verdict();
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sleep_req = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdc(A_MODE, 32'hffff, 32'h0);
    rdc(A_STA, 32'h1, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, A_BRG, 32'h0);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, A_MODE, (i == 1) ? 32'h0300 : (i == 4) ? 32'h8100 : 32'h8000 | (32'(i) << 8));
      repeat (2) @(posedge pclk);
      chk({29'h0, tx_oe, rts_oe, bclk_oe}, {29'h0, pins[i]});
    end
    q[0] = bclk;
    @(posedge pclk);
    chk({31'h0, bclk}, {31'h0, !q[0]});
    endt("pins");
    apb(1'b1, A_MODE, 32'h8000);
    fork
      asp_remote_i.send(9'h0a5, 8, -1, 1'b1);
      begin
        repeat (60) @(posedge pclk);
        rdc(A_STA, 32'h10, 32'h0);
      end
    join
    rdc(A_STA, 32'h11, 32'h11);
    rdc(A_RXD, 32'h1ff, 32'h0a5);
    rdc(A_STA, 32'h1, 32'h0);
    apb(1'b1, A_MODE, 32'h8002);
    asp_remote_i.send(9'h0a5, 8, 1, 1'b1);
    asp_remote_i.send(9'h03c, 8, 0, 1'b0);
    rdc(A_STA, 32'hc, 32'h8);
    apb(1'b0, A_RXD, 32'h0);
    rdc(A_STA, 32'hc, 32'h4);
    apb(1'b0, A_RXD, 32'h0);
    endt("receive");
    apb(1'b1, A_MODE, 32'h8006);
    apb(1'b1, A_STA, 32'h20);
    asp_remote_i.send(9'h012, 9, -1, 1'b1);
    rdc(A_STA, 32'h1, 32'h0);
    asp_remote_i.send(9'h1a5, 9, -1, 1'b1);
    rdc(A_RXD, 32'h1ff, 32'h1a5);
    apb(1'b1, A_MODE, 32'h8000);
    asp_remote_i.send(9'h012, 8, -1, 1'b1);
    rdc(A_RXD, 32'h1ff, 32'h012);
    apb(1'b1, A_STA, 32'h0);
    endt("address");
    apb(1'b1, A_MODE, 32'h8040);
    apb(1'b1, A_TXD, 32'h3c);
    repeat (40) @(posedge pclk);
    chk({31'h0, tx_pin}, 32'h1);
    repeat (200) @(posedge pclk);
    rdc(A_RXD, 32'h1ff, 32'h03c);
    apb(1'b1, A_MODE, 32'h8800);
    fork
      asp_remote_i.recv(w);
      apb(1'b1, A_TXD, 32'h96);
    join
    chk({24'h0, w}, 32'h96);
    chk({31'h0, rts_n}, 32'h0);
    repeat (40) @(posedge pclk);
    endt("transmit");
    apb(1'b1, A_MODE, 32'h8080);
    sleep_req <= 1'b1;
    fork
      asp_remote_i.send(9'h000, 8, -1, 1'b1);
      begin
        n = 0;
        while (wake_irq !== 1'b1 && n < 20) begin
          @(posedge pclk);
          n++;
        end
        chk({31'h0, wake_irq}, 32'h1);
      end
    join
    sleep_req <= 1'b0;
    rdc(A_MODE, 32'h80, 32'h0);
    endt("wake");
    apb(1'b1, A_MODE, 32'h8000);
    for (int i = 0; i < 5; i++) begin
      asp_remote_i.send(9'(i), 8, -1, 1'b1);
    end
    rdc(A_STA, 32'h3, 32'h3);
    chk({31'h0, rts_n}, 32'h1);
    apb(1'b1, A_STA, 32'h0);
    rdc(A_STA, 32'h3, 32'h0);
    chk({31'h0, rts_n}, 32'h0);
    endt("overflow");
    apb(1'b1, A_MODE, 32'h8020);
    asp_remote_i.bt = 48;
    asp_remote_i.send(9'h055, 8, -1, 1'b1);
    // a late frame from the sync tail would show up here
    repeat (500) @(posedge pclk);
    rdc(A_MODE, 32'h20, 32'h0);
    rdc(A_BRG, 32'hffff, 32'h2);
    rdc(A_STA, 32'h1, 32'h0);
    endt("autorate");
    apb(1'b1, A_MODE, 32'h9008);
    repeat (4) @(posedge pclk);
    chk({31'h0, tx_pin}, 32'h1);
    apb(1'b1, A_MODE, 32'h9000);
    repeat (4) @(posedge pclk);
    chk({31'h0, tx_pin}, 32'h0);
    endt("infrared");
    print_verdict();
  end
endmodule // async_serial_port_mode_status_tb
